// File: design/spi_flash_program_erase_pkg.sv
// constants for the flash program and erase sequencer
package spi_flash_program_erase_pkg;
    localparam logic [7:0] OP_CHIP_ERASE_A = 8'h60;
    localparam logic [7:0] OP_CHIP_ERASE_B = 8'hc7;
    localparam logic [7:0] OP_PAGE_PROG    = 8'h02;
    localparam logic [7:0] OP_DUAL_PROG    = 8'ha2;
    localparam logic [7:0] OP_QUAD_PROG    = 8'h32;
    localparam logic [7:0] OP_SEC_ERASE    = 8'h44;
    localparam logic [7:0] OP_SEC_PROG     = 8'h42;
    localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
    localparam int CLK_PERIOD_NS        = 4;
    localparam int CHIP_ERASE_TIME_US   = 2000;
    localparam int PAGE_PROGRAM_TIME_US = 500;
    localparam int SECTOR_ERASE_TIME_US = 1000;
    localparam int CHIP_ERASE_CYCLES   = CHIP_ERASE_TIME_US * 1000 / CLK_PERIOD_NS;
    localparam int PAGE_PROGRAM_CYCLES = PAGE_PROGRAM_TIME_US * 1000 / CLK_PERIOD_NS;
    localparam int SECTOR_ERASE_CYCLES = SECTOR_ERASE_TIME_US * 1000 / CLK_PERIOD_NS;
    localparam int SEC_BYTES      = 512;
    localparam int CMD_BYTES_ONLY = 1;
    localparam int CMD_BYTES_ADDR = 4;
    localparam logic [11:0] BYTE_CNT_MAX = 12'hfff;
    localparam logic [3:0]  BYTE_BITS    = 4'h8;
    localparam logic [3:0]  SEC_AREA_MIN = 4'h1;
    localparam logic [3:0]  SEC_AREA_MAX = 4'h3;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_WALK = 3'b010,
        ST_BUSY = 3'b100
    } seq_state_t;
endpackage : spi_flash_program_erase_pkg

// File: design/spi_flash_program_erase.sv
// serial flash program and erase command sequencer
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - chip erase needs write enable latch set
// - chip erase opcodes 60 or c7, opcode only
// - chip erase only if select rises on byte boundary
// - erase cycle holds progress flag, then clears latch
// - chip erase refused if any protect bit set
// - page program: latch, opcode, address, data bytes
// - program data wraps within the addressed page
// - only last 256 page bytes are programmed
// - short program touches only addressed bytes
// - program rejected unless select rises on boundary
// - program cycle holds progress flag, then clears latch
// - no program into a protected page
// - dual program takes data two bits per clock
// - quad program needs quad enable, four bits
// - three secure areas selected by address fields
// - secure erase: latch, opcode, address, boundary
// - secure erase lasts sector erase time
// - locked secure area ignores erase
// - secure program: address offset, 1 to 512 bytes
// - secure program lasts page program time
// - locked secure area ignores program
module spi_flash_program_erase #(
    parameter int unsigned CHIP_ERASE_CYCLES   = spi_flash_program_erase_pkg::CHIP_ERASE_CYCLES,
    parameter int unsigned PAGE_PROGRAM_CYCLES = spi_flash_program_erase_pkg::PAGE_PROGRAM_CYCLES,
    parameter int unsigned SECTOR_ERASE_CYCLES = spi_flash_program_erase_pkg::SECTOR_ERASE_CYCLES
) (
    input  wire logic        sys_clk_i,
    input  wire logic        sys_rst_i,
    input  wire logic        spi_clk_i,
    input  wire logic        spi_cs_n_i,
    input  wire logic [3:0]  data_line_i,
    input  wire logic [4:0]  block_protect_i,
    input  wire logic        quad_enable_bit_i,
    input  wire logic [2:0]  secure_area_lock_bits_i,
    output logic             write_enable_latch_o,
    output logic             write_in_progress_o,
    output logic             prog_valid_o,
    output logic [23:0]      prog_addr_o,
    output logic [7:0]       prog_data_o,
    output logic             prog_secure_o,
    output logic             chip_erase_o,
    output logic             secure_erase_o,
    output logic [1:0]       secure_area_o
);
    // walk of the buffer must end inside the program time
    if (PAGE_PROGRAM_CYCLES <= spi_flash_program_erase_pkg::SEC_BYTES ||
        CHIP_ERASE_CYCLES < 1 || SECTOR_ERASE_CYCLES < 1) begin : g_bad_timing
        $error("timing parameters too small");
    end

    typedef struct packed {
        logic                                 sclk_s1;
        logic                                 sclk_s2;
        logic                                 sclk_s3;
        logic                                 cs_s1;
        logic                                 cs_s2;
        logic                                 cs_s3;
        logic [3:0]                           dat_s1;
        logic [3:0]                           dat_s2;
        logic [2:0]                           bit_cnt;
        logic [11:0]                          byte_cnt;
        logic [7:0]                           shift;
        logic [7:0]                           opcode;
        logic [23:0]                          addr;
        logic [8:0]                           wr_idx;
        logic [511:0][7:0]                    buffer;
        logic [511:0]                         mask;
        spi_flash_program_erase_pkg::seq_state_t state;
        logic [8:0]                           walk_idx;
        logic [31:0]                          timer;
        logic                                 secure;
        logic                                 write_enable_latch;
        logic                                 write_in_progress;
        logic                                 prog_valid;
        logic [23:0]                          prog_addr;
        logic [7:0]                           prog_data;
        logic                                 chip_erase;
        logic                                 sec_erase;
        logic [1:0]                           area;
    } seq_t;

    seq_t q;
    seq_t d;

    logic       sclk_rise;
    logic       cs_rise;
    logic       cs_fall;
    logic [2:0] lanes;
    logic [3:0] bit_sum;
    logic [7:0] next_shift;
    logic       on_boundary;
    logic       is_prog;
    logic       sec_addr_ok;
    logic       sec_locked;
    logic       page_protected;

    always_comb begin
        sclk_rise   = q.sclk_s2 & ~q.sclk_s3;
        cs_rise     = q.cs_s2 & ~q.cs_s3;
        cs_fall     = ~q.cs_s2 & q.cs_s3;
        on_boundary = (q.bit_cnt == 3'h0);
        // data phase width follows the opcode
        lanes = 3'h1;
        if (q.byte_cnt >= 12'(spi_flash_program_erase_pkg::CMD_BYTES_ADDR)) begin
            if (q.opcode == spi_flash_program_erase_pkg::OP_DUAL_PROG) begin
                lanes = 3'h2;
            end else if (q.opcode == spi_flash_program_erase_pkg::OP_QUAD_PROG) begin
                lanes = 3'h4;
            end
        end
        case (lanes)
            3'h2:    next_shift = {q.shift[5:0], q.dat_s2[1:0]};
            3'h4:    next_shift = {q.shift[3:0], q.dat_s2};
            default: next_shift = {q.shift[6:0], q.dat_s2[0]};
        endcase
        bit_sum = {1'b0, q.bit_cnt} + {1'b0, lanes};
        is_prog = (q.opcode == spi_flash_program_erase_pkg::OP_PAGE_PROG) ||
                  (q.opcode == spi_flash_program_erase_pkg::OP_DUAL_PROG) ||
                  (q.opcode == spi_flash_program_erase_pkg::OP_QUAD_PROG && quad_enable_bit_i);
        sec_addr_ok = (q.addr[23:16] == 8'h00) && (q.addr[11:9] == 3'h0) &&
                      (q.addr[15:12] >= spi_flash_program_erase_pkg::SEC_AREA_MIN) &&
                      (q.addr[15:12] <= spi_flash_program_erase_pkg::SEC_AREA_MAX);
        sec_locked = secure_area_lock_bits_i[2'(q.addr[13:12] - 2'h1)];
        // protection map kept coarse: any protect setting guards the whole array
        page_protected = (block_protect_i != 5'h00);

        d = q;
        d.sclk_s1    = spi_clk_i;
        d.sclk_s2    = q.sclk_s1;
        d.sclk_s3    = q.sclk_s2;
        d.cs_s1      = spi_cs_n_i;
        d.cs_s2      = q.cs_s1;
        d.cs_s3      = q.cs_s2;
        d.dat_s1     = data_line_i;
        d.dat_s2     = q.dat_s1;
        d.prog_valid = 1'b0;
        d.chip_erase = 1'b0;
        d.sec_erase  = 1'b0;

        if (cs_fall) begin
            d.bit_cnt  = 3'h0;
            d.byte_cnt = 12'h000;
            d.opcode   = 8'h00;
            d.shift    = 8'h00;
        end else if (!q.cs_s2 && sclk_rise) begin
            d.shift   = next_shift;
            d.bit_cnt = bit_sum[2:0];
            if (bit_sum == spi_flash_program_erase_pkg::BYTE_BITS) begin
                if (q.byte_cnt != spi_flash_program_erase_pkg::BYTE_CNT_MAX) begin
                    d.byte_cnt = q.byte_cnt + 12'h001;
                end
                if (q.byte_cnt == 12'h000) begin
                    d.opcode = next_shift;
                end else if (q.byte_cnt < 12'(spi_flash_program_erase_pkg::CMD_BYTES_ADDR)) begin
                    d.addr = {q.addr[15:0], next_shift};
                    // buffer is only touched while idle, the running walk reads it
                    if (q.byte_cnt == 12'h003 && q.state == spi_flash_program_erase_pkg::ST_IDLE) begin
                        d.mask   = '0;
                        d.wr_idx = (q.opcode == spi_flash_program_erase_pkg::OP_SEC_PROG) ?
                                   {q.addr[0], next_shift} : {1'b0, next_shift};
                    end
                end else if (q.state == spi_flash_program_erase_pkg::ST_IDLE) begin
                    d.buffer[q.wr_idx] = next_shift;
                    d.mask[q.wr_idx]   = 1'b1;
                    if (q.opcode == spi_flash_program_erase_pkg::OP_SEC_PROG) begin
                        d.wr_idx = q.wr_idx + 9'h001;
                    end else begin
                        d.wr_idx = {1'b0, q.wr_idx[7:0] + 8'h01};
                    end
                end
            end
        end

        // commands land only on select rising, only while idle
        if (cs_rise && on_boundary && q.state == spi_flash_program_erase_pkg::ST_IDLE) begin
            if (q.opcode == spi_flash_program_erase_pkg::OP_WRITE_ENABLE &&
                q.byte_cnt == 12'(spi_flash_program_erase_pkg::CMD_BYTES_ONLY)) begin
                d.write_enable_latch = 1'b1;
            end else if ((q.opcode == spi_flash_program_erase_pkg::OP_CHIP_ERASE_A ||
                          q.opcode == spi_flash_program_erase_pkg::OP_CHIP_ERASE_B) &&
                         q.byte_cnt == 12'(spi_flash_program_erase_pkg::CMD_BYTES_ONLY) &&
                         q.write_enable_latch && !page_protected) begin
                d.chip_erase = 1'b1;
                d.state      = spi_flash_program_erase_pkg::ST_BUSY;
                d.timer      = CHIP_ERASE_CYCLES;
            end else if (is_prog && q.write_enable_latch && !page_protected &&
                         q.byte_cnt > 12'(spi_flash_program_erase_pkg::CMD_BYTES_ADDR)) begin
                d.secure   = 1'b0;
                d.walk_idx = 9'h000;
                d.state    = spi_flash_program_erase_pkg::ST_WALK;
                d.timer    = PAGE_PROGRAM_CYCLES;
            end else if (q.opcode == spi_flash_program_erase_pkg::OP_SEC_ERASE && q.write_enable_latch &&
                         q.byte_cnt == 12'(spi_flash_program_erase_pkg::CMD_BYTES_ADDR) &&
                         sec_addr_ok && !sec_locked) begin
                d.sec_erase = 1'b1;
                d.area      = q.addr[13:12];
                d.state     = spi_flash_program_erase_pkg::ST_BUSY;
                d.timer     = SECTOR_ERASE_CYCLES;
            end else if (q.opcode == spi_flash_program_erase_pkg::OP_SEC_PROG && q.write_enable_latch &&
                         q.byte_cnt > 12'(spi_flash_program_erase_pkg::CMD_BYTES_ADDR) &&
                         sec_addr_ok && !sec_locked) begin
                d.secure   = 1'b1;
                d.area     = q.addr[13:12];
                d.walk_idx = 9'h000;
                d.state    = spi_flash_program_erase_pkg::ST_WALK;
                d.timer    = PAGE_PROGRAM_CYCLES;
            end
        end

        case (q.state)
            spi_flash_program_erase_pkg::ST_IDLE: begin
            end
            spi_flash_program_erase_pkg::ST_WALK: begin
                // walk runs inside the program time, so the cycle length is unchanged
                d.timer = q.timer - 32'h1;
                if (q.mask[q.walk_idx] && (q.secure || !q.walk_idx[8])) begin
                    d.prog_valid = 1'b1;
                    d.prog_data  = q.buffer[q.walk_idx];
                    d.prog_addr  = q.secure ? {q.addr[23:9], q.walk_idx} :
                                              {q.addr[23:8], q.walk_idx[7:0]};
                end
                d.walk_idx = q.walk_idx + 9'h001;
                if (q.walk_idx == 9'h1ff) begin
                    d.state = spi_flash_program_erase_pkg::ST_BUSY;
                end
            end
            spi_flash_program_erase_pkg::ST_BUSY: begin
                d.timer = q.timer - 32'h1;
                if (q.timer <= 32'h1) begin
                    d.state = spi_flash_program_erase_pkg::ST_IDLE;
                    d.write_enable_latch   = 1'b0;
                end
            end
            default: begin
                d.state = spi_flash_program_erase_pkg::ST_IDLE;
            end
        endcase
        d.write_in_progress = (d.state != spi_flash_program_erase_pkg::ST_IDLE);
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            q          <= '0;
            q.sclk_s1  <= 1'b0;
            q.cs_s1    <= 1'b1;
            q.cs_s2    <= 1'b1;
            q.cs_s3    <= 1'b1;
            q.state    <= spi_flash_program_erase_pkg::ST_IDLE;
        end else begin
            q <= d;
        end
    end

    assign write_enable_latch_o = q.write_enable_latch;
    assign write_in_progress_o  = q.write_in_progress;
    assign prog_valid_o         = q.prog_valid;
    assign prog_addr_o          = q.prog_addr;
    assign prog_data_o          = q.prog_data;
    assign prog_secure_o        = q.secure;
    assign chip_erase_o         = q.chip_erase;
    assign secure_erase_o       = q.sec_erase;
    assign secure_area_o        = q.area;

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (sys_rst_i);

    chk_ce_latch: assert property (q.chip_erase |-> $past(q.write_enable_latch))
        else $error("chip erase without write enable latch");
    chk_ce_opcode: assert property (q.chip_erase |-> ($past(q.opcode) == 8'h60 ||
        $past(q.opcode) == 8'hc7) && $past(q.byte_cnt) == 12'h001)
        else $error("chip erase from wrong opcode or length");
    chk_ce_boundary: assert property (q.chip_erase |-> $past(q.bit_cnt) == 3'h0)
        else $error("chip erase off byte boundary");
    chk_ce_wip: assert property (q.chip_erase |-> q.write_in_progress ##1 q.write_in_progress[*8])
        else $error("progress flag not held during erase");
    chk_ce_protect: assert property (q.chip_erase |-> $past(block_protect_i) == 5'h00)
        else $error("chip erase with protection set");
    chk_end_latch: assert property ($fell(q.write_in_progress) |-> !q.write_enable_latch)
        else $error("latch not cleared at cycle end");
    chk_busy_start: assert property ((q.chip_erase || q.sec_erase) |-> !$past(q.write_in_progress))
        else $error("operation started while busy");
    chk_page_wrap: assert property ((q.prog_valid && !q.secure) |->
        q.prog_addr[23:8] == q.addr[23:8])
        else $error("program address left its page");
    chk_sec_lock: assert property (q.sec_erase |-> !$past(sec_locked) && $past(sec_addr_ok))
        else $error("locked or bad secure area erased");
    chk_sec_time: assert property ($rose(q.sec_erase) |-> q.timer == SECTOR_ERASE_CYCLES)
        else $error("secure erase time wrong");

    // every self-timed cycle needs the latch and a clean byte boundary
    chk_start_latch: assert property ($rose(q.write_in_progress) |-> $past(q.write_enable_latch))
        else $error("operation started without write enable latch");
    chk_start_boundary: assert property ($rose(q.write_in_progress) |-> $past(q.bit_cnt) == 3'h0)
        else $error("operation started off byte boundary");

    // array program start: protection and quad enable seen one edge earlier
    chk_pp_protect: assert property (($rose(q.write_in_progress) && !q.chip_erase && !q.sec_erase &&
        !q.secure) |-> $past(block_protect_i) == 5'h00)
        else $error("program into protected array");
    chk_quad_enable: assert property (($rose(q.write_in_progress) &&
        $past(q.opcode) == spi_flash_program_erase_pkg::OP_QUAD_PROG) |->
        $past(quad_enable_bit_i))
        else $error("quad program without quad enable");

    // program timer loaded with the full page time, walk included
    chk_pp_time: assert property (($rose(q.write_in_progress) && !q.chip_erase && !q.sec_erase) |->
        q.timer == PAGE_PROGRAM_CYCLES)
        else $error("program cycle time wrong");
    chk_ce_time: assert property (q.chip_erase |-> q.timer == CHIP_ERASE_CYCLES)
        else $error("chip erase time wrong");
    chk_cycle_end: assert property ($fell(q.write_in_progress) |-> $past(q.timer) <= 32'h1)
        else $error("cycle ended before its timer");

    // secure program checks lock and area like secure erase does
    chk_sp_lock: assert property (($rose(q.write_in_progress) && q.secure) |->
        !$past(sec_locked) && $past(sec_addr_ok))
        else $error("locked or bad secure area programmed");
    chk_sec_wrap: assert property ((q.prog_valid && q.secure) |->
        q.prog_addr[23:9] == q.addr[23:9])
        else $error("secure program left its area");

    // byte writes only inside a running cycle, never alongside an erase
    chk_pv_busy: assert property (q.prog_valid |-> q.write_in_progress && !q.chip_erase && !q.sec_erase)
        else $error("program byte outside a program cycle");
    chk_one_op: assert property (q.chip_erase |-> !q.sec_erase)
        else $error("two operations started together");

    cov_chip_erase: cover property (q.chip_erase);
    cov_page_prog: cover property (q.prog_valid && !q.secure);
    cov_sec_prog: cover property (q.prog_valid && q.secure);
    cov_sec_erase: cover property (q.sec_erase);
    cov_cycle_end: cover property ($fell(q.write_in_progress));
endmodule : spi_flash_program_erase
`default_nettype wire

// File: dv/spi_host_model.sv
// host serial controller model driving select, clock and data lines
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
    output logic       spi_clk_o,
    output logic       spi_cs_n_o,
    output logic [3:0] data_line_o
);
    initial begin
        spi_clk_o   = 1'b0;
        spi_cs_n_o  = 1'b1;
        data_line_o = 4'h0;
    end
    // clock only moves inside frames, 125 ns period
    task automatic put(input logic [3:0] v);
        data_line_o = v;
        #62.5 spi_clk_o = 1'b1;
        #62.5 spi_clk_o = 1'b0;
    endtask : put
    // hdr bytes on line 0, the rest on lanes lines, then stray bits
    task automatic frame(input logic [7:0] b[$], input int hdr, input int lanes, input int extra);
        spi_cs_n_o = 1'b0;
        #62.5;
        foreach (b[i]) begin
            int w;
            w = (i < hdr) ? 1 : lanes;
            for (int s = 8 - w; s >= 0; s -= w) begin
                put(4'((b[i] >> s) & ((1 << w) - 1)));
            end
        end
        repeat (extra) put(4'h1);
        #62.5 spi_cs_n_o = 1'b1;
        // released lines must not keep the old value
        data_line_o = ~data_line_o;
        #250;
    endtask : frame
endmodule : spi_host_model
`default_nettype wire

// File: dv/spi_flash_program_erase_tb_top.sv
// self-checking bench for the flash program and erase sequencer
`timescale 1ns/1ps
`default_nettype none
module spi_flash_program_erase_tb_top;
    localparam int         CE_CYC = 600;
    localparam int         PP_CYC = 600;
    localparam int         SE_CYC = 100;
    localparam logic [7:0] WE_OP  = spi_flash_program_erase_pkg::OP_WRITE_ENABLE;
    logic        sys_clk_i = 1'b0;
    logic        sys_rst_i = 1'b1;
    logic        spi_clk;
    logic        spi_cs_n;
    logic [3:0]  data_line;
    logic [4:0]  protect   = 5'h00;
    logic        quad_en   = 1'b0;
    logic [2:0]  lock      = 3'h0;
    logic        write_enable_latch, write_in_progress, pv, psec, ce, se;
    logic [23:0] paddr;
    logic [7:0]  pdata;
    logic [1:0]  sarea;
    int          err_count = 0;
    int          tests_run = 0;
    int          cyc = 0, n_ce = 0, n_se = 0, n_wip = 0, cur = 0, wip_len = 0;
    logic [31:0] wr_q[$];

    always #2 sys_clk_i = ~sys_clk_i;

    spi_host_model host (
        .spi_clk_o   (spi_clk),
        .spi_cs_n_o  (spi_cs_n),
        .data_line_o (data_line)
    );
    // short timers keep the run small; walk needs more than 512
    spi_flash_program_erase #(
        .CHIP_ERASE_CYCLES   (CE_CYC),
        .PAGE_PROGRAM_CYCLES (PP_CYC),
        .SECTOR_ERASE_CYCLES (SE_CYC)
    ) dut (
        .sys_clk_i               (sys_clk_i),
        .sys_rst_i               (sys_rst_i),
        .spi_clk_i               (spi_clk),
        .spi_cs_n_i              (spi_cs_n),
        .data_line_i             (data_line),
        .block_protect_i         (protect),
        .quad_enable_bit_i       (quad_en),
        .secure_area_lock_bits_i (lock),
        .write_enable_latch_o    (write_enable_latch),
        .write_in_progress_o     (write_in_progress),
        .prog_valid_o            (pv),
        .prog_addr_o             (paddr),
        .prog_data_o             (pdata),
        .prog_secure_o           (psec),
        .chip_erase_o            (ce),
        .secure_erase_o          (se),
        .secure_area_o           (sarea)
    );

    task automatic finish_test();
        if (err_count == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : finish_test

    always @(posedge sys_clk_i) begin
        cyc <= cyc + 1;
        if (pv === 1'b1) wr_q.push_back({paddr, pdata});
        if (ce === 1'b1) n_ce <= n_ce + 1;
        if (se === 1'b1) n_se <= n_se + 1;
        if (write_in_progress === 1'b1) begin
            cur <= cur + 1;
            if (cur == 0) n_wip <= n_wip + 1;
        end else if (cur != 0) begin
            wip_len <= cur;
            cur     <= 0;
        end
        if (cyc == 60000) begin
            err_count++;
            finish_test();
        end
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // bounded wait until the self-timed cycle is over
    task automatic settle();
        int k;
        k = 0;
        while (write_in_progress === 1'b1 && k < 5000) begin
            @(posedge sys_clk_i);
            k++;
        end
        repeat (4) @(posedge sys_clk_i);
    endtask : settle

    task automatic run(input logic [7:0] b[$], input int hdr, lanes, extra, input bit we);
        wr_q.delete();
        if (we) host.frame('{WE_OP}, 1, 1, 0);
        host.frame(b, hdr, lanes, extra);
        settle();
    endtask : run

    task automatic t_chip_erase();
        int c;
        c = n_ce;
        run('{8'h60}, 1, 1, 0, 1'b0);
        check("ce_no_latch", n_ce - c, 0);
        for (int i = 0; i < 2; i++) begin
            run('{i ? 8'hc7 : 8'h60}, 1, 1, 0, 1'b1);
            check("ce_pulse", n_ce - c, i + 1);
            check("ce_busy", 32'(wip_len inside {CE_CYC, CE_CYC + 1}), 1);
            check("ce_latch", write_enable_latch, 1'b0);
        end
    endtask : t_chip_erase

    task automatic t_refuse();
        int w;
        w = n_wip;
        @(negedge sys_clk_i) protect = 5'h10;
        run('{8'hc7}, 1, 1, 0, 1'b1);
        check("ce_prot_latch", write_enable_latch, 1'b1);
        run('{8'h02, 8'h00, 8'h00, 8'h00, 8'h55}, 4, 1, 0, 1'b0);
        run('{8'ha2, 8'h00, 8'h00, 8'h00, 8'h55}, 4, 2, 0, 1'b0);
        @(negedge sys_clk_i) protect = 5'h00;
        run('{8'h60}, 1, 1, 3, 1'b0);
        run('{8'h02, 8'h00, 8'h00, 8'h00, 8'h55}, 4, 1, 5, 1'b0);
        run('{8'h32, 8'h00, 8'h00, 8'h00, 8'h55}, 4, 4, 0, 1'b0);
        check("refused_ops", n_wip - w, 0);
        check("refused_latch", write_enable_latch, 1'b1);
    endtask : t_refuse

    task automatic t_page();
        run('{8'h02, 8'h00, 8'h12, 8'hfe, 8'ha1, 8'ha2, 8'ha3}, 4, 1, 0, 1'b1);
        check("pp_count", wr_q.size(), 3);
        check("pp_wrap", wr_q[0], {24'h001200, 8'ha3});
        check("pp_first", wr_q[1], {24'h0012fe, 8'ha1});
        check("pp_second", wr_q[2], {24'h0012ff, 8'ha2});
        check("pp_busy", 32'(wip_len inside {PP_CYC, PP_CYC + 1}), 1);
        check("pp_latch", write_enable_latch, 1'b0);
    endtask : t_page

    task automatic t_multi();
        logic [7:0] b[$];
        run('{8'ha2, 8'h00, 8'h20, 8'h10, 8'h3c, 8'hc3}, 4, 2, 0, 1'b1);
        check("dpp_a", wr_q[0], {24'h002010, 8'h3c});
        check("dpp_b", wr_q[1], {24'h002011, 8'hc3});
        @(negedge sys_clk_i) quad_en = 1'b1;
        b = '{8'h32, 8'h00, 8'h04, 8'h00};
        // the two overflow bytes are marked so they differ from slots 0 and 1
        for (int i = 0; i < 258; i++) b.push_back(8'(i) ^ (i > 255 ? 8'hc0 : 8'h00));
        run(b, 4, 4, 0, 1'b1);
        check("qpp_count", wr_q.size(), 256);
        foreach (wr_q[s]) check("qpp_slot", wr_q[s], {16'h0004, 8'(s), 8'(s) ^ (s < 2 ? 8'hc0 : 8'h00)});
    endtask : t_multi

    task automatic t_secure();
        int w;
        w = n_se;
        run('{8'h44, 8'h00, 8'h20, 8'h00}, 4, 1, 0, 1'b1);
        check("se_pulse", n_se - w, 1);
        check("se_area", sarea, 2'h2);
        check("se_busy", 32'(wip_len inside {SE_CYC, SE_CYC + 1}), 1);
        @(negedge sys_clk_i) lock = 3'h2;
        w = n_wip;
        run('{8'h44, 8'h00, 8'h20, 8'h00}, 4, 1, 0, 1'b1);
        run('{8'h42, 8'h00, 8'h20, 8'h00, 8'h77}, 4, 1, 0, 1'b0);
        check("sp_locked", wr_q.size(), 0);
        run('{8'h44, 8'h00, 8'h40, 8'h00}, 4, 1, 0, 1'b0);
        run('{8'h44, 8'h00, 8'h12, 8'h00}, 4, 1, 0, 1'b0);
        check("sec_refused", n_wip - w, 0);
        run('{8'h42, 8'h00, 8'h31, 8'hff, 8'h5a, 8'ha5}, 4, 1, 0, 1'b0);
        check("sp_wrap", wr_q[0], {24'h003000, 8'ha5});
        check("sp_last", wr_q[1], {24'h0031ff, 8'h5a});
        check("sp_secure", psec, 1'b1);
        check("sp_busy", 32'(wip_len inside {PP_CYC, PP_CYC + 1}), 1);
    endtask : t_secure

    task automatic t_busy();
        int c;
        c = n_ce;
        host.frame('{WE_OP}, 1, 1, 0);
        host.frame('{8'h60}, 1, 1, 0);
        // second erase lands while the first is still running
        host.frame('{8'hc7}, 1, 1, 0);
        settle();
        check("busy_reject", n_ce - c, 1);
        check("busy_latch", write_enable_latch, 1'b0);
    endtask : t_busy

    initial begin
        repeat (20) @(negedge sys_clk_i);
        sys_rst_i = 1'b0;
        repeat (3) @(negedge sys_clk_i);
        check("rst_latch", write_enable_latch, 1'b0);
        check("rst_busy", write_in_progress, 1'b0);
        t_chip_erase();
        t_refuse();
        t_page();
        t_multi();
        t_secure();
        t_busy();
        finish_test();
    end
endmodule : spi_flash_program_erase_tb_top
`default_nettype wire
